/* File: logic/epiu_regs.svh */
// register map, field positions and reset values of the pin interrupt unit
`ifndef EPIU_REGS_SVH
`define EPIU_REGS_SVH
`define EPIU_ADDR_SENSE 8'h00
`define EPIU_ADDR_ENABLE 8'h04
`define EPIU_ADDR_FLAGS 8'h08
`define EPIU_ADDR_PCMASK0 8'h0C
`define EPIU_ADDR_PCMASK1 8'h10
`define EPIU_ADDR_PCMASK2 8'h14
`define EPIU_ADDR_PCMASK3 8'h18
`define EPIU_ADDR_STATUS 8'h1C
`define EPIU_BIT_DED 0
`define EPIU_BIT_GRP0 4
`define EPIU_SENSE_LOW 2'h0
`define EPIU_SENSE_ANY 2'h1
`define EPIU_SENSE_FALL 2'h2
`define EPIU_SENSE_RISE 2'h3
`define EPIU_RESET_BYTE 8'h00
`define EPIU_RESP_OKAY 2'h0
`define EPIU_RESP_SLVERR 2'h2
`endif

/* File: logic/epiu_pkg.sv */
// types shared by the pin interrupt unit
`include "epiu_regs.svh"
package epiu_pkg;
  // trigger selection of the dedicated input
  typedef enum logic [1:0] {
    EPIU_LOW = `EPIU_SENSE_LOW,
    EPIU_ANY = `EPIU_SENSE_ANY,
    EPIU_FALL = `EPIU_SENSE_FALL,
    EPIU_RISE = `EPIU_SENSE_RISE
  } epiu_sense_e;
  // request lines toward the cpu, also used for acknowledges
  typedef struct packed {
    logic [3:0] group;
    logic dedicated;
  } epiu_irq_s;
endpackage

/* File: logic/epiu_top.sv */
// external pin and pin-change interrupt unit with axi4-lite registers
//
// How it works
// R1: pins trigger even when driven as outputs
// R2: groups 1/0 request on unmasked toggles
// R3: pin change wakes without the clock
// R4: level mode requests while pin low
// R5: edges only detected while clock runs
// R6: low level wakes without the clock
// R7: level gone before start-up: no request
// R8: dedicated request needs global and enable
// R9: detect from sampled, not raw, pin
// R10: pulses over one period are caught
// R11: source holds level until instruction ends
// R12: sense field picks low/any/fall/rise
// R13: enable bit 7 gates group 3
// R14: enable bit 6 gates group 2
// R15: enable bit 5 gates group 1
// R16: enable bit 4 gates group 0
// R17: enable bit 0 gates dedicated input
// R18: per-pin mask bits gate group change
// R19: group flag set, cleared ack or w1c
// R20: dedicated flag, zero in level mode
// R21: request held until ack clears flag
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "epiu_regs.svh"
module epiu_top #(
  parameter int AW = 8, // axi address width
  parameter bit GROUP3_PRESENT = 1'b1 // variant has group 3
) (
  input wire logic clk, // 25 mhz i/o clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic io_clock_run, // i/o clock not halted
  input wire logic cpu_global_enable, // global enable from cpu
  input wire logic dedicated_irq_input, // raw dedicated pin
  input wire logic [30:0] pin_change_inputs, // raw pin-change pins
  input wire epiu_pkg::epiu_irq_s cpu_ack, // vector taken pulses
  output epiu_pkg::epiu_irq_s cpu_req, // requests to cpu
  output logic wake_request, // asynchronous wake
  input wire logic [AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import epiu_pkg::*;

  // group widths: three full bytes and a seven-pin top group
  function automatic logic [7:0] grp_pins(input logic [30:0] v,
                                          input int g);
    logic [7:0] r;
    r = 8'h00;
    case (g)
      0: r = v[7:0];
      1: r = v[15:8];
      2: r = v[23:16];
      default: r = {1'b0, v[30:24]};
    endcase
    return r;
  endfunction

  // address match against a register offset, word aligned
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0] ext_int_sense_control; // sense control register
  logic [7:0] ext_int_enable_mask; // enable mask register
  logic [7:0] pin_change_mask [4]; // per-pin masks
  logic ded_flag; // dedicated input flag
  logic [3:0] grp_flag; // pin change group flags
  logic ded_s1, ded_s2, ded_s3; // dedicated pin samples
  logic [30:0] pc_s1, pc_s2, pc_s3; // pin-change samples
  epiu_sense_e sense; // decoded trigger mode
  logic ded_edge; // selected edge seen
  logic [3:0] grp_hit; // unmasked change per group
  logic [3:0] grp_en; // group enable bits
  logic [AW-1:0] aw_addr; // latched write address
  logic aw_held, w_held; // halves of a write taken
  logic [7:0] w_byte; // latched write byte
  logic w_lane; // low lane strobed
  logic do_write; // both halves present
  logic [3:0] w1c_grp; // group flags cleared by software
  logic w1c_ded; // dedicated flag cleared by software

  assign sense = epiu_sense_e'(ext_int_sense_control[1:0]); // R12
  assign grp_en = {ext_int_enable_mask[7] & GROUP3_PRESENT,
                   ext_int_enable_mask[6:4]};

  ////////////////////////////////////////////////////////////////////
  // input synchronisers; the pad level is sampled whatever the pin
  // direction, so a driven output can raise its own interrupt
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ded_s1 <= 1'b1;
      ded_s2 <= 1'b1;
      ded_s3 <= 1'b1;
    end else begin
      ded_s1 <= dedicated_irq_input; // R1
      ded_s2 <= ded_s1; // R9
      ded_s3 <= ded_s2;
    end
  end

  // pin-change samples: third stage holds the last seen level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_s1 <= 31'h0000000;
      pc_s2 <= 31'h0000000;
      pc_s3 <= 31'h0000000;
    end else begin
      pc_s1 <= pin_change_inputs; // R1
      pc_s2 <= pc_s1;
      pc_s3 <= pc_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // event detection from the sampled values
  always_comb begin
    // edges only while the i/o clock runs, as in sleep it is gated
    ded_edge = 1'b0;
    if (io_clock_run) begin // R5
      unique case (sense)
        EPIU_LOW: ded_edge = 1'b0;
        EPIU_ANY: ded_edge = ded_s2 ^ ded_s3; // R12
        EPIU_FALL: ded_edge = ded_s3 & ~ded_s2; // R12
        EPIU_RISE: ded_edge = ~ded_s3 & ded_s2; // R12
      endcase
    end
  end

  // any unmasked toggle per group; a pulse wider than a period
  // always lands in the second stage for at least one cycle
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      grp_hit[g] = |(grp_pins(pc_s2 ^ pc_s3, g) &
                     pin_change_mask[g]); // R2 R10 R18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags: a new event wins over an ack or a software clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      grp_flag <= 4'h0;
    end else begin
      grp_flag <= grp_hit | (grp_flag & ~cpu_ack.group & ~w1c_grp);
    end // R19 R21
  end

  // level mode keeps the flag at zero; the request is the sampled pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ded_flag <= 1'b0;
    end else if (sense == EPIU_LOW) begin
      ded_flag <= 1'b0; // R20
    end else begin
      ded_flag <= ded_edge |
                  (ded_flag & ~cpu_ack.dedicated & ~w1c_ded); // R20 R21
    end
  end

  ////////////////////////////////////////////////////////////////////
  // requests toward the cpu; level requests follow the sampled pin,
  // so a level that vanished before start-up leaves no request
  always_comb begin
    cpu_req.dedicated = cpu_global_enable &
                        ext_int_enable_mask[`EPIU_BIT_DED] & // R8 R17
                        ((sense == EPIU_LOW) ? ~ded_s2 : ded_flag);
    // R4 R7
    cpu_req.group = grp_flag & grp_en &
                    {4{cpu_global_enable}}; // R13 R14 R15 R16
  end

  // wake path works with the clock stopped: compares the raw pins
  // to the last sampled level; limitation: a glitch can wake too
  always_comb begin
    wake_request = ext_int_enable_mask[`EPIU_BIT_DED] &
                   (sense == EPIU_LOW) & ~dedicated_irq_input; // R6
    for (int g = 0; g < 4; g++) begin
      wake_request = wake_request | (grp_en[g] &
        |(grp_pins(pin_change_inputs ^ pc_s3, g) &
          pin_change_mask[g])); // R3
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held;

  // hold each half until the pair completes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write-one-to-clear decode for the flag register
  always_comb begin
    w1c_grp = 4'h0;
    w1c_ded = 1'b0;
    if (do_write && w_lane && hit(aw_addr, `EPIU_ADDR_FLAGS)) begin
      w1c_grp = w_byte[7:4]; // R19
      w1c_ded = w_byte[`EPIU_BIT_DED]; // R20
    end
  end

  // control register writes; upper byte lanes are ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_int_sense_control <= `EPIU_RESET_BYTE;
      ext_int_enable_mask <= `EPIU_RESET_BYTE;
      for (int g = 0; g < 4; g++) begin
        pin_change_mask[g] <= `EPIU_RESET_BYTE;
      end
    end else if (do_write && w_lane) begin
      if (hit(aw_addr, `EPIU_ADDR_SENSE)) begin
        ext_int_sense_control <= {6'h00, w_byte[1:0]}; // R12
      end
      if (hit(aw_addr, `EPIU_ADDR_ENABLE)) begin
        ext_int_enable_mask <= {w_byte[7] & GROUP3_PRESENT,
                                w_byte[6:4], 3'h0, w_byte[0]};
      end
      if (hit(aw_addr, `EPIU_ADDR_PCMASK0)) begin
        pin_change_mask[0] <= w_byte; // R18
      end
      if (hit(aw_addr, `EPIU_ADDR_PCMASK1)) begin
        pin_change_mask[1] <= w_byte; // R18
      end
      if (hit(aw_addr, `EPIU_ADDR_PCMASK2)) begin
        pin_change_mask[2] <= w_byte; // R18
      end
      if (hit(aw_addr, `EPIU_ADDR_PCMASK3) && GROUP3_PRESENT) begin
        pin_change_mask[3] <= {1'b0, w_byte[6:0]}; // R18
      end
    end
  end

  // write response one cycle after the pair; unmapped gets slverr
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPIU_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[7:0] <= `EPIU_ADDR_STATUS &&
                      aw_addr[1:0] == 2'h0) ?
                     `EPIU_RESP_OKAY : `EPIU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi read channel: one cycle latency, one read at a time
  assign s_axi_arready = !s_axi_rvalid;

  // status register shows sampled pin and live requests
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EPIU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EPIU_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (hit(s_axi_araddr, `EPIU_ADDR_SENSE)) begin
        s_axi_rdata[7:0] <= ext_int_sense_control;
      end else if (hit(s_axi_araddr, `EPIU_ADDR_ENABLE)) begin
        s_axi_rdata[7:0] <= ext_int_enable_mask;
      end else if (hit(s_axi_araddr, `EPIU_ADDR_FLAGS)) begin
        s_axi_rdata[7:0] <= {grp_flag & {GROUP3_PRESENT, 3'h7},
                             3'h0, ded_flag};
      end else if (hit(s_axi_araddr, `EPIU_ADDR_PCMASK0)) begin
        s_axi_rdata[7:0] <= pin_change_mask[0];
      end else if (hit(s_axi_araddr, `EPIU_ADDR_PCMASK1)) begin
        s_axi_rdata[7:0] <= pin_change_mask[1];
      end else if (hit(s_axi_araddr, `EPIU_ADDR_PCMASK2)) begin
        s_axi_rdata[7:0] <= pin_change_mask[2];
      end else if (hit(s_axi_araddr, `EPIU_ADDR_PCMASK3)) begin
        s_axi_rdata[7:0] <= pin_change_mask[3];
      end else if (hit(s_axi_araddr, `EPIU_ADDR_STATUS)) begin
        s_axi_rdata[7:0] <= {2'h0, cpu_req.group, cpu_req.dedicated,
                             ded_s2};
      end else begin
        s_axi_rresp <= `EPIU_RESP_SLVERR; // unmapped
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_level_request: assert property ( // R4
    (sense == EPIU_LOW) && ext_int_enable_mask[0] &&
    cpu_global_enable && !ded_s2 |-> cpu_req.dedicated)
    else $error("level request missing while pin low");

  a_level_flag_zero: assert property ( // R20
    $past(sense == EPIU_LOW) |-> !ded_flag)
    else $error("dedicated flag set in level mode");

  a_rise_sets_flag: assert property ( // R12
    (sense == EPIU_RISE) && io_clock_run && !ded_s3 && ded_s2
    ##1 (sense == EPIU_RISE) |-> ded_flag)
    else $error("rising edge not flagged");

  a_fall_sets_flag: assert property ( // R12
    (sense == EPIU_FALL) && io_clock_run && ded_s3 && !ded_s2
    ##1 (sense == EPIU_FALL) |-> ded_flag)
    else $error("falling edge not flagged");

  a_no_edge_halted: assert property ( // R5
    $rose(ded_flag) |-> $past(io_clock_run))
    else $error("edge flagged with clock halted");

  a_ded_gate: assert property ( // R8
    cpu_req.dedicated |-> cpu_global_enable && ext_int_enable_mask[0])
    else $error("dedicated request without enables");

  a_mask_blocks: assert property ( // R18
    !grp_flag[0] && pin_change_mask[0] == 8'h00 |=> !grp_flag[0])
    else $error("masked pins set group 0 flag");

  a_change_sets: assert property ( // R2
    pc_s2[9] != pc_s3[9] && pin_change_mask[1][1] |=> grp_flag[1])
    else $error("unmasked toggle not flagged");

  a_ack_clears: assert property ( // R21
    grp_flag[0] && cpu_ack.group[0] && !grp_hit[0] |=> !grp_flag[0])
    else $error("ack did not clear group 0 flag");

  a_req_holds: assert property ( // R21
    cpu_req.group[1] && !cpu_ack.group[1] && !w1c_grp[1] &&
    $stable(ext_int_enable_mask) ##1 cpu_global_enable &&
    $stable(ext_int_enable_mask) |-> cpu_req.group[1])
    else $error("group 1 request dropped without ack");

  a_wake_level: assert property ( // R6
    ext_int_enable_mask[0] && (sense == EPIU_LOW) &&
    !dedicated_irq_input |-> wake_request)
    else $error("low level did not request wake");

  c_level_req: cover property (
    (sense == EPIU_LOW) && cpu_req.dedicated);
  c_group_ack: cover property (
    cpu_req.group[0] ##[1:20] cpu_ack.group[0]);
  c_write_resp: cover property (do_write ##1 s_axi_bvalid);
endmodule // epiu_top

/* File: dv/epiu_cpu_model.sv */
// cpu side model: takes pending vectors and pulses their acknowledge
`timescale 1ns/10ps
module epiu_cpu_model (
  input wire logic clk, // i/o clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ack_en, // take vectors only while high
  input wire logic [3:0] ack_delay, // cycles a request waits first
  input wire epiu_pkg::epiu_irq_s cpu_req, // requests seen
  output epiu_pkg::epiu_irq_s cpu_ack, // one-cycle take pulses
  output logic [7:0] ack_count // vectors taken so far
);
  import epiu_pkg::*;
  logic [3:0] wait_cnt; // cycles the pending request has waited
  //////////////////////////////////////////////////////////////////////
  // dedicated vector first, then the lowest group; skip the cycle
  // after a take, since the request only drops one edge later
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_ack <= '0;
      wait_cnt <= 4'h0;
      ack_count <= 8'h00;
    end else begin
      cpu_ack <= '0;
      if (!ack_en || cpu_ack != '0 || cpu_req == '0) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt != ack_delay) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= 4'h0;
        ack_count <= ack_count + 8'h01;
        cpu_ack.dedicated <= cpu_req.dedicated;
        cpu_ack.group <= cpu_req.dedicated ? 4'h0 :
          (cpu_req.group & (~cpu_req.group + 4'h1));
      end
    end
  end
endmodule // epiu_cpu_model

/* File: dv/epiu_tb.sv */
// self-checking bench of the pin interrupt unit
`timescale 1ns/10ps
`include "epiu_regs.svh"
module tb;
  import epiu_pkg::*;
  logic clk, nrst, io_run, glob, ded, ack_en, wake;
  logic [30:0] pins; // pin-change pins, also usable as outputs
  logic [3:0] ack_delay, wstrb;
  epiu_irq_s cpu_ack, cpu_req;
  logic [7:0] awaddr, araddr, ack_count;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] req_v; // bit 0 dedicated, bits 4:1 groups
  int failures = 0;
  int checked = 0;
  assign req_v = cpu_req;
  always #20 clk = ~clk;
  epiu_top u_dut (.clk(clk), .nrst(nrst), .io_clock_run(io_run),
    .cpu_global_enable(glob), .dedicated_irq_input(ded),
    .pin_change_inputs(pins), .cpu_ack(cpu_ack), .cpu_req(cpu_req),
    .wake_request(wake), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  epiu_cpu_model u_cpu (.clk(clk), .nrst(nrst), .ack_en(ack_en),
    .ack_delay(ack_delay), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
    .ack_count(ack_count));
  //////////////////////////////////////////////////////////////////////
  // value compare, x never matches
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // axi write: halves released as taken, ready sampled on negedge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ra, rw, ad, wd, rb;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    rb = 1'b0;
    while (!(ad && wd)) begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      @(posedge clk);
      if (ra && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (rw && !wd) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    while (!rb) begin
      @(negedge clk);
      rb = bvalid;
      rs = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    chk("bresp", er, rs);
  endtask
  // axi read with expected data and response
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
          input string nm);
    logic ra, rb;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ra = 1'b0;
    rb = 1'b0;
    while (!ra) begin
      @(negedge clk);
      ra = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    while (!rb) begin
      @(negedge clk);
      rb = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    chk(nm, e, d);
    chk("rresp", er, rs);
  endtask
  // bounded wait for one request line to reach a level
  task wait_req(input int i, input logic e, input string nm);
    int n;
    for (n = 0; n < 8; n++) begin
      @(negedge clk);
      if (req_v[i] === e) break;
    end
    chk(nm, e, req_v[i]);
  endtask
  task settle;
    repeat (6) @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  // reset values and an unmapped place
  task t_reset;
    int a;
    for (a = 0; a <= 8'h18; a += 4) rd(a[7:0], 0, 2'h0, "reset reg");
    rd(8'h20, 0, `EPIU_RESP_SLVERR, "unmapped");
    wr(8'h20, 32'hFF, `EPIU_RESP_SLVERR);
  endtask
  // each group: masked pin ignored, unmasked toggle requests, ack clears
  task t_groups;
    int g;
    for (g = 0; g < 4; g++) begin
      wr(8'h0C + 8'(4 * g), 32'h02, 2'h0);
      wr(`EPIU_ADDR_ENABLE, 32'h10 << g, 2'h0);
      @(posedge clk) pins[8 * g + 2] <= ~pins[8 * g + 2];
      settle;
      chk("masked pin", 0, req_v[1 + g]);
      @(posedge clk) pins[8 * g + 1] <= ~pins[8 * g + 1];
      wait_req(1 + g, 1'b1, "group req");
      rd(`EPIU_ADDR_FLAGS, 32'h10 << g, 2'h0, "group flag");
      @(posedge clk) ack_en <= 1'b1;
      wait_req(1 + g, 1'b0, "req after ack");
      chk("acks", g + 1, ack_count);
      @(posedge clk) ack_en <= 1'b0;
      rd(`EPIU_ADDR_FLAGS, 0, 2'h0, "flag after ack");
      wr(8'h0C + 8'(4 * g), 0, 2'h0);
    end
  endtask
  // every sense code, global gating, level mode
  task t_sense;
    int m;
    wr(`EPIU_ADDR_ENABLE, 32'h01, 2'h0);
    for (m = 1; m < 4; m++) begin
      wr(`EPIU_ADDR_SENSE, m, 2'h0);
      @(posedge clk) ded <= 1'b0;
      settle;
      chk("fall req", m != 3, req_v[0]);
      rd(`EPIU_ADDR_FLAGS, m != 3, 2'h0, "fall flag");
      wr(`EPIU_ADDR_FLAGS, 32'h01, 2'h0);
      @(posedge clk) ded <= 1'b1;
      settle;
      rd(`EPIU_ADDR_FLAGS, m != 2, 2'h0, "rise flag");
      wr(`EPIU_ADDR_FLAGS, 32'h01, 2'h0);
    end
    rd(`EPIU_ADDR_STATUS, 32'h01, 2'h0, "status pin");
    wr(`EPIU_ADDR_SENSE, `EPIU_SENSE_FALL, 2'h0);
    @(posedge clk) glob <= 1'b0;
    ded <= 1'b0;
    settle;
    chk("no global", 0, req_v[0]);
    @(posedge clk) glob <= 1'b1;
    wait_req(0, 1'b1, "global on");
    wr(`EPIU_ADDR_FLAGS, 32'h01, 2'h0);
    wait_req(0, 1'b0, "w1c clear");
    @(posedge clk) ded <= 1'b1;
    wr(`EPIU_ADDR_SENSE, `EPIU_SENSE_LOW, 2'h0);
    @(posedge clk) ded <= 1'b0;
    wait_req(0, 1'b1, "level req");
    repeat (10) @(posedge clk);
    chk("level held", 1, req_v[0]);
    rd(`EPIU_ADDR_FLAGS, 0, 2'h0, "level flag");
    rd(`EPIU_ADDR_STATUS, 32'h02, 2'h0, "status low");
    wr(`EPIU_ADDR_ENABLE, 32'h00, 2'h0);
    wait_req(0, 1'b0, "enable off");
    wr(`EPIU_ADDR_ENABLE, 32'h01, 2'h0);
    wait_req(0, 1'b1, "enable on");
    @(posedge clk) ded <= 1'b1;
    wait_req(0, 1'b0, "level gone");
  endtask
  // clock halted: edges missed, low level and pin change still wake
  task t_wake;
    wr(`EPIU_ADDR_SENSE, `EPIU_SENSE_FALL, 2'h0);
    @(posedge clk) io_run <= 1'b0;
    ded <= 1'b0;
    settle;
    rd(`EPIU_ADDR_FLAGS, 0, 2'h0, "halted edge");
    @(posedge clk) ded <= 1'b1;
    wr(`EPIU_ADDR_SENSE, `EPIU_SENSE_LOW, 2'h0);
    @(posedge clk) ded <= 1'b0;
    @(negedge clk) chk("level wake", 1, wake);
    @(posedge clk) ded <= 1'b1;
    wr(`EPIU_ADDR_ENABLE, 32'h10, 2'h0);
    wr(`EPIU_ADDR_PCMASK0, 32'h01, 2'h0);
    @(posedge clk) pins[0] <= ~pins[0];
    @(negedge clk) chk("change wake", 1, wake);
    @(posedge clk) io_run <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 20000);
    failures++;
    test_done;
  end
  // main sequence; pulses held many cycles, well over one period
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    io_run = 1'b1;
    glob = 1'b1;
    ded = 1'b1;
    ack_en = 1'b0;
    ack_delay = 4'h2;
    pins = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_groups;
    t_sense;
    t_wake;
    test_done;
  end
endmodule // tb
